// ### ftr_map.svh
// Purpose: Named offsets, field positions, codes and counts for the
//          track-read / sector-write command interpreter.
// Assumes: Included by the design module and the bench top.
// Notes:   Definitions only.
`ifndef FTR_MAP_SVH
`define FTR_MAP_SVH

// Command and result byte counts
`define FTR_NCMD 4'h9
`define FTR_LAST_CMD 4'h8
`define FTR_LAST_RES 3'h6

// Command byte positions
`define FTR_B_OPC 0
`define FTR_B_SEL 1
`define FTR_B_CYL 2
`define FTR_B_HD 3
`define FTR_B_SEC 4
`define FTR_B_SZ 5
`define FTR_B_EOT 6
`define FTR_B_GPL 7
`define FTR_B_DTL 8

// Opcode fields
`define FTR_OP_MT 7
`define FTR_OP_MFM 6
`define FTR_OP_SK 5
`define FTR_TRK_CODE 5'h02
`define FTR_WR_CODE 6'h05

// Select byte fields
`define FTR_SEL_HD 2

// Completion codes
`define FTR_IC_OK 2'h0
`define FTR_IC_ABN 2'h1
`define FTR_IC_BAD 2'h2

// Status bit positions
`define FTR_ST1_EN 7
`define FTR_ST1_DE 5
`define FTR_ST1_OR 4
`define FTR_ST1_MA 0
`define FTR_ST2_DD 5

// Sector geometry and CRC
`define FTR_BASE_LEN 15'h0080
`define FTR_SHORT_LEN 8'h80
`define FTR_CRC_INIT 16'hFFFF
`define FTR_CRC_POLY 16'h1021
`define FTR_FIRST_SEC 8'h01

`endif

// ### ftr_pkg.sv
// Purpose: Types shared by the track-read / sector-write interpreter.
// Assumes: ftr_map.svh holds the numeric constants.
// Notes:   Types only; no logic.
package ftr_pkg;

  // Command phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_RT_IDX,
    PH_RT_READ,
    PH_WR_DATA,
    PH_WR_CRC_HI,
    PH_WR_CRC_LO,
    PH_RESULT
  } ftr_phase_t;

  // The nine command bytes, byte 0 first
  typedef logic [8:0][7:0] ftr_cmd_t;

  // Whole module state
  typedef struct packed {
    ftr_phase_t ph;
    logic [3:0] idx;
    ftr_cmd_t prm;
    logic [1:0] ic;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [14:0] cnt;
    logic zfill;
    logic tc_seen;
    logic [15:0] crc;
    logic id_seen;
    logic [7:0] sec_cnt;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic disk_wr_valid;
    logic [7:0] disk_wr_byte;
  } ftr_state_t;

endpackage

// ### ftr_ctrl.sv
// Purpose: Command interpreter for the track-read and sector-write floppy
//          commands: command bytes in, data execution, seven result bytes out.
// Assumes: Drive side gives a decoded byte stream with marker pulses and asks
//          for write bytes by a one-cycle request strobe.
// Notes:   Only the two commands are decoded; anything else ends as invalid.
`timescale 1ns/100ps
`include "ftr_map.svh"

module ftr_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command bytes from host
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  // Result bytes to host
  output logic res_valid,
  output logic [7:0] res_byte,
  input wire logic res_ready,
  // Track-read data to host
  output logic rd_valid,
  output logic [7:0] rd_byte,
  // Sector-write data from host
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  output logic wr_ready,
  input wire logic terminal_count,
  // Drive read side
  input wire logic index_pulse,
  input wire logic disk_rd_valid,
  input wire logic [7:0] disk_rd_byte,
  input wire logic disk_id_found,
  input wire logic disk_sec_end,
  input wire logic disk_id_crc_err,
  input wire logic disk_data_crc_err,
  // Drive write side
  input wire logic disk_wr_req,
  output logic disk_wr_valid,
  output logic [7:0] disk_wr_byte,
  // Drive selection and status
  output logic head_select,
  output logic [1:0] drive_select,
  output logic busy
);

  ftr_pkg::ftr_state_t s; // Registered state
  ftr_pkg::ftr_state_t next_s; // Next state
  logic [14:0] sec_len; // Bytes in one sector
  logic [14:0] data_lim; // Bytes taken from host per sector
  logic last_byte; // Current byte ends the data field
  logic at_eot; // Current sector is the final one
  logic [7:0] st0; // Status byte 0 as reported

  // CCITT CRC step over one byte, most significant bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ `FTR_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Sector geometry; short data length only counts when N is zero
  always_comb begin
    sec_len = `FTR_BASE_LEN << s.prm[`FTR_B_SZ][2:0];
    if (s.prm[`FTR_B_SZ] == 8'h00 && s.prm[`FTR_B_DTL] < `FTR_SHORT_LEN) begin
      data_lim = {7'h00, s.prm[`FTR_B_DTL]};
    end else begin
      data_lim = sec_len;
    end
    last_byte = (s.cnt == sec_len - 15'h0001);
    at_eot = (s.prm[`FTR_B_SEC] == s.prm[`FTR_B_EOT]);
  end

  // Status byte 0: completion code, head and drive as selected
  assign st0 = {s.ic, 3'h0, s.prm[`FTR_B_SEL][`FTR_SEL_HD:0]};
  assign head_select = s.prm[`FTR_B_SEL][`FTR_SEL_HD];
  assign drive_select = s.prm[`FTR_B_SEL][1:0];
  assign busy = (s.ph != ftr_pkg::PH_IDLE);
  assign cmd_ready = (s.ph == ftr_pkg::PH_IDLE) || (s.ph == ftr_pkg::PH_CMD);
  assign res_valid = (s.ph == ftr_pkg::PH_RESULT);
  assign rd_valid = s.rd_valid;
  assign rd_byte = s.rd_byte;
  assign disk_wr_valid = s.disk_wr_valid;
  assign disk_wr_byte = s.disk_wr_byte;

  // Host data is accepted only on a drive request inside the data limit
  assign wr_ready = (s.ph == ftr_pkg::PH_WR_DATA) && disk_wr_req && !s.zfill &&
                    !terminal_count && (s.cnt < data_lim);

  // Result byte order: three status bytes, then the sector ID
  always_comb begin
    case (s.idx[2:0])
      3'h0: res_byte = st0;
      3'h1: res_byte = s.st1;
      3'h2: res_byte = s.st2;
      3'h3: res_byte = s.prm[`FTR_B_CYL];
      3'h4: res_byte = s.prm[`FTR_B_HD];
      3'h5: res_byte = s.prm[`FTR_B_SEC];
      default: res_byte = s.prm[`FTR_B_SZ];
    endcase
  end

  // Next-state logic for every phase
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.disk_wr_valid = 1'b0;
    case (s.ph)
      // Opcode byte starts a command
      ftr_pkg::PH_IDLE: begin
        if (cmd_valid) begin
          next_s.prm[`FTR_B_OPC] = cmd_byte;
          next_s.idx = 4'h1;
          next_s.ic = `FTR_IC_OK;
          next_s.st1 = 8'h00;
          next_s.st2 = 8'h00;
          next_s.ph = ftr_pkg::PH_CMD;
        end
      end
      // Remaining eight bytes land in order
      ftr_pkg::PH_CMD: begin
        if (cmd_valid) begin
          next_s.prm[s.idx] = cmd_byte;
          next_s.idx = s.idx + 4'h1;
          if (s.idx == `FTR_LAST_CMD) begin
            next_s.idx = 4'h0;
            next_s.cnt = 15'h0000;
            next_s.zfill = 1'b0;
            next_s.tc_seen = 1'b0;
            next_s.crc = `FTR_CRC_INIT;
            next_s.id_seen = 1'b0;
            next_s.sec_cnt = 8'h00;
            // Host keeps multitrack low for track read; bit 7 must be zero
            if (!s.prm[`FTR_B_OPC][`FTR_OP_MT] &&
                s.prm[`FTR_B_OPC][4:0] == `FTR_TRK_CODE) begin
              next_s.ph = ftr_pkg::PH_RT_IDX;
            end else if (s.prm[`FTR_B_OPC][5:0] == `FTR_WR_CODE) begin
              next_s.ph = ftr_pkg::PH_WR_DATA;
            end else begin
              next_s.ic = `FTR_IC_BAD;
              next_s.ph = ftr_pkg::PH_RESULT;
            end
          end
        end
      end
      // Nothing moves until the index hole passes
      ftr_pkg::PH_RT_IDX: begin
        if (index_pulse) begin
          next_s.ph = ftr_pkg::PH_RT_READ;
        end
      end
      // Stream every data field; errors only mark status
      ftr_pkg::PH_RT_READ: begin
        next_s.rd_valid = disk_rd_valid;
        next_s.rd_byte = disk_rd_byte;
        if (disk_id_found) begin
          next_s.id_seen = 1'b1;
        end
        if (disk_id_crc_err || disk_data_crc_err) begin
          next_s.st1[`FTR_ST1_DE] = 1'b1;
        end
        if (disk_data_crc_err) begin
          next_s.st2[`FTR_ST2_DD] = 1'b1;
        end
        if (disk_sec_end) begin
          next_s.sec_cnt = s.sec_cnt + 8'h01;
          next_s.prm[`FTR_B_SEC] = s.prm[`FTR_B_SEC] + 8'h01;
          if (s.sec_cnt + 8'h01 == s.prm[`FTR_B_EOT]) begin
            next_s.ph = ftr_pkg::PH_RESULT;
          end
        end else if (index_pulse) begin
          // Second index before the final sector is abnormal
          next_s.ic = `FTR_IC_ABN;
          next_s.st1[`FTR_ST1_MA] = !s.id_seen;
          next_s.ph = ftr_pkg::PH_RESULT;
        end else if (terminal_count) begin
          next_s.ph = ftr_pkg::PH_RESULT;
        end
      end
      // One byte per drive request: host data, else zeros
      ftr_pkg::PH_WR_DATA: begin
        if (terminal_count) begin
          next_s.zfill = 1'b1;
          next_s.tc_seen = 1'b1;
        end
        if (disk_wr_req) begin
          next_s.disk_wr_valid = 1'b1;
          next_s.cnt = s.cnt + 15'h0001;
          if (wr_ready && wr_valid) begin
            next_s.disk_wr_byte = wr_byte;
            next_s.crc = crc_step(s.crc, wr_byte);
          end else begin
            // Short data length, terminal count or underrun: pad with zero
            next_s.disk_wr_byte = 8'h00;
            next_s.crc = crc_step(s.crc, 8'h00);
            if (wr_ready) begin
              next_s.st1[`FTR_ST1_OR] = 1'b1;
              next_s.zfill = 1'b1;
            end
          end
          if (last_byte) begin
            next_s.ph = ftr_pkg::PH_WR_CRC_HI;
          end
        end
      end
      // CRC field, high byte first
      ftr_pkg::PH_WR_CRC_HI: begin
        if (disk_wr_req) begin
          next_s.disk_wr_valid = 1'b1;
          next_s.disk_wr_byte = s.crc[15:8];
          next_s.ph = ftr_pkg::PH_WR_CRC_LO;
        end
      end
      // Low CRC byte, then step to the next sector
      ftr_pkg::PH_WR_CRC_LO: begin
        if (disk_wr_req) begin
          next_s.disk_wr_valid = 1'b1;
          next_s.disk_wr_byte = s.crc[7:0];
          next_s.cnt = 15'h0000;
          next_s.crc = `FTR_CRC_INIT;
          next_s.prm[`FTR_B_SEC] = s.prm[`FTR_B_SEC] + 8'h01;
          next_s.ph = ftr_pkg::PH_WR_DATA;
          if (s.tc_seen || s.st1[`FTR_ST1_OR]) begin
            next_s.ph = ftr_pkg::PH_RESULT;
          end else if (at_eot) begin
            next_s.prm[`FTR_B_SEC] = `FTR_FIRST_SEC;
            if (s.prm[`FTR_B_OPC][`FTR_OP_MT] && !s.prm[`FTR_B_HD][0]) begin
              // Continue on side one of the same cylinder
              next_s.prm[`FTR_B_HD] = s.prm[`FTR_B_HD] + 8'h01;
              next_s.prm[`FTR_B_SEL][`FTR_SEL_HD] = 1'b1;
            end else begin
              // Ran off the cylinder without terminal count
              next_s.prm[`FTR_B_CYL] = s.prm[`FTR_B_CYL] + 8'h01;
              next_s.st1[`FTR_ST1_EN] = 1'b1;
              next_s.ic = `FTR_IC_ABN;
              next_s.ph = ftr_pkg::PH_RESULT;
            end
          end
        end
      end
      // Seven result bytes, one per host read
      ftr_pkg::PH_RESULT: begin
        if (res_ready) begin
          next_s.idx = s.idx + 4'h1;
          if (s.idx[2:0] == `FTR_LAST_RES) begin
            next_s.idx = 4'h0;
            next_s.ph = ftr_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        next_s.ph = ftr_pkg::PH_IDLE;
      end
    endcase
  end

  // State register; every field clears on reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ### ftr_chk.sv
// Purpose: Port-level checks on the command interpreter
// Assumes: Bound from the bench top; one clock domain
// Notes: Watches the design's outputs and the host and drive inputs they answer to
`timescale 1ns/100ps
module ftr_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host side
  input wire logic cmd_ready,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_byte,
  // Drive side
  input wire logic disk_rd_valid,
  input wire logic [7:0] disk_rd_byte,
  input wire logic disk_wr_req,
  input wire logic disk_wr_valid,
  input wire logic [7:0] disk_wr_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Request met by a host byte, or by an empty host side
  sequence s_take; disk_wr_req && wr_ready && wr_valid; endsequence
  sequence s_under; disk_wr_req && wr_ready && !wr_valid; endsequence
  chk_wr_answer: assert property (disk_wr_req |=> disk_wr_valid)
    else $error("no write byte after request");
  chk_wr_quiet: assert property (!disk_wr_req |=> !disk_wr_valid)
    else $error("write byte without request");
  chk_wr_data: assert property (s_take |=> disk_wr_byte == $past(wr_byte))
    else $error("host byte not passed on");
  chk_under_zero: assert property (s_under |=> disk_wr_byte == 8'h00)
    else $error("underrun byte not zero");
  chk_rd_copy: assert property (rd_valid |-> $past(disk_rd_valid) &&
    rd_byte == $past(disk_rd_byte))
    else $error("track byte not from drive");
  chk_rd_busy: assert property (rd_valid |-> busy && !res_valid)
    else $error("track byte outside execution");
  chk_res_excl: assert property (res_valid |-> busy && !cmd_ready)
    else $error("result overlaps command phase");
  chk_res_pop: assert property ($fell(res_valid) |-> $past(res_ready))
    else $error("result ended without a read");
  chk_idle_ready: assert property (!busy |-> cmd_ready)
    else $error("idle but refusing commands");
endmodule

// ### ftr_drive.sv
// Purpose: Behavioural floppy drive facing the interpreter
// Assumes: Strobes change on the falling edge
// Notes: Idle data bus shows the inverse of the last byte
`timescale 1ns/100ps
module ftr_drive (
  // Clock
  input wire logic clk,
  // Read side
  output logic index_pulse,
  output logic disk_rd_valid,
  output logic [7:0] disk_rd_byte,
  output logic disk_id_found,
  output logic disk_sec_end,
  output logic disk_id_crc_err,
  output logic disk_data_crc_err,
  // Write side
  output logic disk_wr_req
);
  initial {index_pulse, disk_rd_valid, disk_rd_byte, disk_id_found} = '0;
  initial {disk_sec_end, disk_id_crc_err, disk_data_crc_err, disk_wr_req} = '0;
  // One track pass: index, then ID and three data bytes per sector
  task automatic track(input int nsec, input int bad, input int idbad, input bit again);
    repeat (3) @(negedge clk);
    @(negedge clk) index_pulse = 1;
    @(negedge clk) index_pulse = 0;
    for (int s = 0; s < nsec; s++) begin
      // ID field fault rides with the address mark
      @(negedge clk) {disk_id_found, disk_id_crc_err} = {1'b1, 1'(s == idbad)};
      @(negedge clk) {disk_id_found, disk_id_crc_err} = 2'b00;
      for (int b = 0; b < 3; b++) begin
        @(negedge clk) {disk_rd_valid, disk_rd_byte} = {1'b1, 8'(s * 16 + b)};
        @(negedge clk) {disk_rd_valid, disk_rd_byte} = {1'b0, ~disk_rd_byte};
      end
      // CRC fault rides with the end of the field
      @(negedge clk) {disk_sec_end, disk_data_crc_err} = {1'b1, 1'(s == bad)};
      @(negedge clk) {disk_sec_end, disk_data_crc_err} = 2'b00;
    end
    // Second index ends an unfinished pass
    if (again) begin
      @(negedge clk) index_pulse = 1;
      @(negedge clk) index_pulse = 0;
    end
  endtask
  // Write byte requests, one every other cycle
  task automatic wreq(input int n);
    repeat (n) begin
      @(negedge clk) disk_wr_req = 1;
      @(negedge clk) disk_wr_req = 0;
    end
  endtask
endmodule

// ### floppy_track_read_sector_write_tb_top.sv
// Purpose: Self-checking bench for the interpreter
// Assumes: Inputs change on the falling edge
// Notes: Terminal count pulses once, in the write_tc scenario
`timescale 1ns/100ps
`include "ftr_map.svh"
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module floppy_track_read_sector_write_tb_top;
  logic clk = 0, nrst = 0, cmd_valid = 0, res_ready = 0, wr_valid = 0, terminal_count = 0;
  logic cmd_ready, res_valid, rd_valid, wr_ready, disk_wr_valid, head_select, busy;
  logic index_pulse, disk_rd_valid, disk_id_found, disk_sec_end, disk_id_crc_err;
  logic disk_data_crc_err, disk_wr_req;
  logic [7:0] cmd_byte = 0, wr_byte = 0, res_byte, rd_byte, disk_rd_byte, disk_wr_byte;
  logic [1:0] drive_select;
  logic [7:0] got [7];
  logic [7:0] hdat [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [7:0] wcap [$];
  int n_errors, samples_checked, hn, hi, n_rd;
  always #4 clk = ~clk;
  ftr_ctrl dut (.clk, .nrst, .cmd_valid, .cmd_byte, .cmd_ready, .res_valid, .res_byte,
    .res_ready, .rd_valid, .rd_byte, .wr_valid, .wr_byte, .wr_ready, .terminal_count,
    .index_pulse, .disk_rd_valid, .disk_rd_byte, .disk_id_found, .disk_sec_end,
    .disk_id_crc_err, .disk_data_crc_err, .disk_wr_req, .disk_wr_valid, .disk_wr_byte,
    .head_select, .drive_select, .busy);
  ftr_drive drv (.clk, .index_pulse, .disk_rd_valid, .disk_rd_byte, .disk_id_found,
    .disk_sec_end, .disk_id_crc_err, .disk_data_crc_err, .disk_wr_req);
  // Host write side: a byte is gone once both sides agree at an edge
  always @(posedge clk) if (wr_valid && wr_ready) hi <= hi + 1;
  always @(negedge clk) begin
    wr_valid <= hi < hn;
    wr_byte <= hdat[hi % 4];
  end
  // Capture what reaches the drive and count track bytes
  always @(posedge clk) begin
    if (disk_wr_valid) wcap.push_back(disk_wr_byte);
    if (rd_valid) n_rd++;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Nine bytes back to back, byte 0 first
  task automatic send_cmd(input ftr_pkg::ftr_cmd_t c);
    for (int i = 0; i < 9; i++) begin
      @(negedge clk) {cmd_valid, cmd_byte} = {1'b1, c[i]};
      @(posedge clk) `CHK(cmd_ready, 1'b1, "command byte refused")
    end
    @(negedge clk) cmd_valid = 0;
  endtask
  // Bounded wait for the result, then seven pops in a row
  task automatic read_res();
    int w;
    w = 0;
    while (res_valid !== 1'b1 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    if (w == 20000) begin
      n_errors++;
      wrap_up();
    end
    for (int i = 0; i < 7; i++) begin
      got[i] = res_byte;
      res_ready = 1;
      @(negedge clk);
    end
    res_ready = 0;
    `CHK(res_valid, 1'b0, "result still offered")
  endtask
  task automatic expect7(input logic [6:0][7:0] e);
    for (int i = 0; i < 7; i++) `CHK(got[i], e[i], "result byte")
  endtask
  // Expected CRC over the first sector: four host bytes, then zeros
  function automatic logic [15:0] crc128();
    logic [15:0] c;
    logic [7:0] d;
    c = `FTR_CRC_INIT;
    for (int i = 0; i < 128; i++) begin
      d = (i < 4) ? hdat[i] : 8'h00;
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? `FTR_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  // Full pass with a data CRC fault in the second sector
  task automatic track_ok();
    n_rd = 0;
    send_cmd({8'hff, 8'h1b, 8'h02, 8'h00, 8'h01, 8'h01, 8'h03, 8'h05, 8'h02});
    `CHK({head_select, drive_select}, 3'b101, "select lines")
    fork drv.track(2, 1, 9, 0); read_res(); join
    `CHK(n_rd, 6, "track bytes")
    expect7({8'h00, 8'h03, 8'h01, 8'h03, 8'h20, 8'h20, 8'h05});
    $display("test track_ok done");
  endtask
  // Second index before the final sector, with an ID field fault on the way
  task automatic track_abort();
    n_rd = 0;
    send_cmd({8'hff, 8'h1b, 8'h05, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'h02});
    fork drv.track(1, 9, 0, 1); read_res(); join
    `CHK(n_rd, 3, "track bytes")
    expect7({8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h20, 8'h40});
    $display("test track_abort done");
  endtask
  // Short data length, last sector, with or without the second side
  task automatic write_end(input bit mt);
    hn = mt ? 8 : 4;
    hi = 0;
    wcap.delete();
    send_cmd({8'h04, 8'h1b, 8'h01, 8'h00, 8'h01, 8'h00, 8'h07, 8'h00, {mt, 7'h05}});
    fork drv.wreq(mt ? 260 : 130); read_res(); join
    `CHK(wcap.size(), mt ? 260 : 130, "write byte count")
    for (int i = 0; i < 128; i++) `CHK(wcap[i], i < 4 ? hdat[i] : 8'h00, "data")
    `CHK({wcap[128], wcap[129]}, crc128(), "crc field")
    `CHK(head_select, mt, "second side")
    expect7({8'h00, 8'h01, {7'h00, mt}, 8'h08, 8'h00, 8'h80, {5'h08, mt, 2'h0}});
    $display("test write_end done");
  endtask
  // Host runs dry after two bytes of a 256-byte sector
  task automatic write_under();
    hn = 2;
    hi = 0;
    wcap.delete();
    send_cmd({8'hff, 8'h1b, 8'h02, 8'h01, 8'h01, 8'h00, 8'h07, 8'h00, 8'h05});
    fork drv.wreq(258); read_res(); join
    `CHK(wcap.size(), 258, "long sector count")
    `CHK({wcap[2], wcap[3]}, 16'h0000, "zero fill")
    `CHK({got[1], got[5]}, 16'h1002, "underrun status")
    $display("test write_under done");
  endtask
  // Terminal count after three host bytes pads the sector and ends the write
  task automatic write_tc();
    hn = 8;
    hi = 0;
    wcap.delete();
    send_cmd({8'hff, 8'h1b, 8'h05, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00, 8'h45});
    fork
      drv.wreq(130);
      read_res();
      begin
        repeat (5) @(negedge clk);
        @(negedge clk) terminal_count = 1;
        @(negedge clk) terminal_count = 0;
      end
    join
    `CHK({wcap[2], wcap[3], wcap[127]}, 24'h33_0000, "tc zero fill")
    `CHK(wcap.size(), 130, "tc write count")
    `CHK({got[0], got[1], got[5]}, 24'h00_0002, "tc result")
    $display("test write_tc done");
  endtask
  task automatic bad_opcode();
    send_cmd({8'hff, 8'h1b, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h1f});
    read_res();
    `CHK(got[0], 8'h80, "invalid completion")
    $display("test bad_opcode done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    track_ok();
    track_abort();
    write_end(0);
    write_end(1);
    write_under();
    write_tc();
    bad_opcode();
    wrap_up();
  end
endmodule
bind ftr_ctrl ftr_chk u_chk (.clk, .nrst, .cmd_ready, .res_valid, .res_ready, .busy,
  .rd_valid, .rd_byte, .wr_valid, .wr_ready, .wr_byte, .disk_rd_valid, .disk_rd_byte,
  .disk_wr_req, .disk_wr_valid, .disk_wr_byte);
